// *** src/qpv_cfg.svh ***
// register offsets, field positions and reset values of the encoder block
`ifndef QPV_CFG_SVH
`define QPV_CFG_SVH

// ******************************************
// register byte offsets
// ******************************************
`define QPV_OFF_CTL 8'h00
`define QPV_OFF_STAT 8'h04
`define QPV_OFF_POS 8'h08
`define QPV_OFF_LIMIT 8'h0c
`define QPV_OFF_LOAD 8'h10
`define QPV_OFF_TIME 8'h14
`define QPV_OFF_ACC 8'h18
`define QPV_OFF_RESULT 8'h1c
`define QPV_OFF_MASK 8'h20
`define QPV_OFF_RAW 8'h24
`define QPV_OFF_CLR 8'h28

// ******************************************
// control field positions
// ******************************************
`define QPV_CTL_W 9
`define QPV_CTL_EN 0
`define QPV_CTL_SWAP 1
`define QPV_CTL_SIG 2
`define QPV_CTL_CAP 3
`define QPV_CTL_RES 4
`define QPV_CTL_VEL 5
`define QPV_CTL_DIV_LSB 6
`define QPV_CTL_DIV_MSB 8

// ******************************************
// status and event bit positions
// ******************************************
`define QPV_STAT_ERR 0
`define QPV_STAT_DIR 1
`define QPV_EV_ERR 3
`define QPV_EV_W 4

// ******************************************
// reset values
// ******************************************
`define QPV_RST_WORD 32'h0000_0000
`define QPV_RST_CTL 9'h000
`define QPV_RST_EV 4'h0

`endif

// *** src/qpv_pkg.sv ***
// shared types of the quadrature position and velocity block
package qpv_pkg;

  // one wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // event bundle, index in bit 0
  typedef struct packed {
    logic err;
    logic dir;
    logic timer;
    logic index;
  } event_t;

  // result of one sampled cycle of phase decoding
  typedef struct packed {
    logic step;
    logic mov;
    logic fwd;
    logic err;
  } decode_t;

endpackage : qpv_pkg

// *** src/qpv_sync.sv ***
// two-flop synchronisers for the encoder pins
`timescale 1ns/1ps
`default_nettype none
module qpv_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and synchronised copies
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);

  // ******************************************
  // one two-stage chain per pin
  // ******************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_chain
      logic meta_ff; // first stage, read by the second stage only
      logic safe_ff; // second stage
      // capture then settle
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_ff <= 1'b0;
          safe_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= async_i[gi];
          safe_ff <= meta_ff;
        end
      end
      assign sync_o[gi] = safe_ff;
    end
  endgenerate

endmodule : qpv_sync
`default_nettype wire

// *** src/qpv_decode.sv ***
// phase decoder: quadrature or clock/direction into steps
`timescale 1ns/1ps
`default_nettype none
module qpv_decode (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // synchronised phases
  input wire logic a_i,
  input wire logic b_i,
  // configuration
  input wire logic swap_i,
  input wire logic sig_i,
  input wire logic cap_i,
  // decoded result
  output qpv_pkg::decode_t dec_o
);

  logic pa; // phase a after optional swap
  logic pb; // phase b after optional swap
  logic pa_q_ff; // previous phase a
  logic pb_q_ff; // previous phase b
  logic ea; // edge on a
  logic eb; // edge on b

  // swap corrects miswired encoders
  assign pa = swap_i ? b_i : a_i;
  assign pb = swap_i ? a_i : b_i;
  assign ea = pa ^ pa_q_ff;
  assign eb = pb ^ pb_q_ff;

  // previous sample for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pa_q_ff <= 1'b0;
      pb_q_ff <= 1'b0;
    end
    else
    begin
      pa_q_ff <= pa;
      pb_q_ff <= pb;
    end
  end

  // ******************************************
  // decode
  // ******************************************
  always_comb
  begin
    dec_o = '0;
    if (sig_i)
    begin
      // rising a is a step, b gives direction (1 = reverse)
      dec_o.step = ea & pa;
      dec_o.mov = ea & pa;
      dec_o.fwd = ~pb;
    end
    else if (ea & eb)
    begin
      // both moved in one sample: illegal gray step, no count
      dec_o.err = 1'b1;
    end
    else
    begin
      // a edge counts always, b edge only in four-edge mode
      dec_o.step = ea | (eb & cap_i);
      dec_o.mov = ea | eb;
      // a leading b gives forward; a repeated edge reverses
      dec_o.fwd = ea ? (pa != pb) : (pa == pb);
    end
  end

endmodule : qpv_decode
`default_nettype wire

// *** src/quadrature_position_velocity.sv ***
// quadrature encoder position, direction and velocity with wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "qpv_cfg.svh"
module quadrature_position_velocity (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // encoder pins
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  input wire logic index_input_i,
  // masked event summary
  output logic irq_o
);

  // ******************************************
  // declarations
  // ******************************************
  qpv_pkg::wb_req_t req; // bundled bus request
  qpv_pkg::decode_t dec; // decoder result
  qpv_pkg::event_t ev; // events of this cycle
  logic [2:0] pins_s; // synchronised index, b, a
  logic idx_q_ff; // previous index sample
  logic idx_rise; // index pulse sensed
  logic [`QPV_CTL_W-1:0] encoder_control_register; // control word
  logic [31:0] pos_ff; // position integrator
  logic [31:0] position_limit; // maximum position
  logic [31:0] velocity_period_reload; // timer reload
  logic [31:0] time_ff; // velocity timer
  logic [31:0] velocity_accumulator; // edges this period
  logic [31:0] velocity_result; // edges last period
  logic [3:0] mask_ff; // event mask
  logic [3:0] raw_ff; // sticky raw events
  logic dir_ff; // 1 = reverse
  logic [6:0] pre_ff; // prescaler count
  logic ack_ff; // bus answer
  logic [31:0] rd_data; // read mux
  logic [31:0] ctl_merged; // control word after byte lanes, cut to width on store
  logic wr_go; // write takes effect this edge
  logic enable; // position integration on
  logic signal_format_select; // 1 = clock/direction
  logic edge_count_select; // 1 = both phases
  logic position_reset_select; // 1 = limit, 0 = index
  logic vel_run; // velocity capture active
  logic [2:0] velocity_prescale; // divide by 2^n
  logic [6:0] pre_top; // prescaler wrap value
  logic vel_inc; // one prescaled edge
  logic expire; // timer at zero while running

  // ******************************************
  // helpers
  // ******************************************
  // true when the committing write addresses the offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  // apply byte enables to a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  // all-ones mask of n low bits, prescaler top
  function automatic logic [6:0] top_of(input logic [2:0] n);
    top_of = 7'((8'h01 << n) - 8'h01);
  endfunction : top_of

  // ******************************************
  // request bundle and field views
  // ******************************************
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  assign enable = encoder_control_register[`QPV_CTL_EN];
  assign signal_format_select = encoder_control_register[`QPV_CTL_SIG];
  assign edge_count_select = encoder_control_register[`QPV_CTL_CAP];
  assign position_reset_select = encoder_control_register[`QPV_CTL_RES];
  assign velocity_prescale =
    encoder_control_register[`QPV_CTL_DIV_MSB:`QPV_CTL_DIV_LSB];
  // velocity needs the integrator enabled as well
  assign vel_run = enable & encoder_control_register[`QPV_CTL_VEL];
  // write lands at the edge the master samples ack
  assign wr_go = req.cyc & req.stb & req.we & ack_ff;
  assign ctl_merged = merge(32'(encoder_control_register), req.dat, req.sel);

  // ******************************************
  // pins and decoder
  // ******************************************
  qpv_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({index_input_i, phase_b_input_i, phase_a_input_i}),
    .sync_o(pins_s)
  );

  qpv_decode u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_i(pins_s[0]),
    .b_i(pins_s[1]),
    .swap_i(encoder_control_register[`QPV_CTL_SWAP]),
    .sig_i(signal_format_select),
    .cap_i(edge_count_select),
    .dec_o(dec)
  );

  // index edge detection on the settled copy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_q_ff <= 1'b0;
    end
    else
    begin
      idx_q_ff <= pins_s[2];
    end
  end
  assign idx_rise = pins_s[2] & ~idx_q_ff;

  // ******************************************
  // bus slave
  // ******************************************
  // one wait cycle, ack for exactly one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      wb_dat_o <= `QPV_RST_WORD;
    end
    else
    begin
      ack_ff <= req.cyc & req.stb & ~ack_ff;
      // read data is caught with the ack
      if (req.cyc & req.stb & ~ack_ff)
      begin
        wb_dat_o <= rd_data;
      end
    end
  end
  assign wb_ack_o = ack_ff;

  // read mux, unmapped offsets read zero
  always_comb
  begin
    rd_data = `QPV_RST_WORD;
    unique case (req.adr)
      `QPV_OFF_CTL: rd_data = 32'(encoder_control_register);
      `QPV_OFF_STAT: rd_data = {30'h0, dir_ff, raw_ff[`QPV_EV_ERR]};
      `QPV_OFF_POS: rd_data = pos_ff;
      `QPV_OFF_LIMIT: rd_data = position_limit;
      `QPV_OFF_LOAD: rd_data = velocity_period_reload;
      `QPV_OFF_TIME: rd_data = time_ff;
      `QPV_OFF_ACC: rd_data = velocity_accumulator;
      `QPV_OFF_RESULT: rd_data = velocity_result;
      `QPV_OFF_MASK: rd_data = {28'h0, mask_ff};
      `QPV_OFF_RAW: rd_data = {28'h0, raw_ff};
      `QPV_OFF_CLR: rd_data = {28'h0, raw_ff & mask_ff};
      default: rd_data = `QPV_RST_WORD;
    endcase
  end

  // ******************************************
  // configuration registers
  // ******************************************
  // software-owned words; limit must be edges per turn minus one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      encoder_control_register <= `QPV_RST_CTL;
      position_limit <= `QPV_RST_WORD;
      velocity_period_reload <= `QPV_RST_WORD;
      mask_ff <= `QPV_RST_EV;
    end
    else if (wr_go)
    begin
      if (hit(req.adr, `QPV_OFF_CTL))
      begin
        encoder_control_register <= ctl_merged[`QPV_CTL_W-1:0];
      end
      if (hit(req.adr, `QPV_OFF_LIMIT))
      begin
        position_limit <= merge(position_limit, req.dat, req.sel);
      end
      if (hit(req.adr, `QPV_OFF_LOAD))
      begin
        velocity_period_reload <= merge(velocity_period_reload, req.dat, req.sel);
      end
      if (hit(req.adr, `QPV_OFF_MASK) && req.sel[0])
      begin
        mask_ff <= req.dat[3:0];
      end
    end
  end

  // ******************************************
  // position integrator
  // ******************************************
  // software write wins, then index clear, then steps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_ff <= `QPV_RST_WORD;
    end
    else if (wr_go && hit(req.adr, `QPV_OFF_POS))
    begin
      pos_ff <= merge(pos_ff, req.dat, req.sel);
    end
    else if (enable && !position_reset_select && idx_rise)
    begin
      // index mode: position counts from the home mark
      pos_ff <= `QPV_RST_WORD;
    end
    else if (enable && dec.step)
    begin
      // limit mode keeps 0..limit; index mode relies on limit = N-1
      if (dec.fwd)
      begin
        pos_ff <= (pos_ff >= position_limit) ? 32'h0 : pos_ff + 32'h1;
      end
      else
      begin
        pos_ff <= (pos_ff == 32'h0) ? position_limit : pos_ff - 32'h1;
      end
    end
  end

  // direction follows every direction-bearing edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_ff <= 1'b0;
    end
    else if (enable && dec.mov)
    begin
      dir_ff <= ~dec.fwd;
    end
  end

  // ******************************************
  // velocity capture
  // ******************************************
  assign pre_top = top_of(velocity_prescale);
  // one accumulated edge per 2^n counted edges
  assign vel_inc = vel_run & dec.step & (pre_ff == pre_top);
  assign expire = vel_run & (time_ff == 32'h0);

  // prescaler; restarts while capture is off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_ff <= 7'h00;
    end
    else if (!vel_run)
    begin
      pre_ff <= 7'h00;
    end
    else if (dec.step)
    begin
      pre_ff <= (pre_ff >= pre_top) ? 7'h00 : pre_ff + 7'h01;
    end
  end

  // down counter; reload enters the cycle after zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      time_ff <= `QPV_RST_WORD;
    end
    else if (!vel_run || expire)
    begin
      // idle keeps the timer primed so the first period is whole
      time_ff <= velocity_period_reload;
    end
    else
    begin
      time_ff <= time_ff - 32'h1;
    end
  end

  // accumulator and result; an edge in the last cycle is kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      velocity_accumulator <= `QPV_RST_WORD;
      velocity_result <= `QPV_RST_WORD;
    end
    else if (expire)
    begin
      velocity_result <= velocity_accumulator + 32'(vel_inc);
      velocity_accumulator <= 32'h0;
    end
    else if (vel_inc)
    begin
      velocity_accumulator <= velocity_accumulator + 32'h1;
    end
  end

  // ******************************************
  // events and status
  // ******************************************
  assign ev.index = enable & idx_rise;
  assign ev.timer = expire;
  assign ev.dir = enable & dec.mov & (dir_ff != ~dec.fwd);
  assign ev.err = enable & dec.err;

  // sticky raw bits, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      raw_ff <= `QPV_RST_EV;
    end
    else if (wr_go && hit(req.adr, `QPV_OFF_CLR) && req.sel[0])
    begin
      raw_ff <= (raw_ff & ~req.dat[3:0]) | ev;
    end
    else
    begin
      raw_ff <= raw_ff | ev;
    end
  end

  // masked summary
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(raw_ff & mask_ff);
    end
  end

  // ******************************************
  // checks
  // ******************************************
  a_pos_fwd_wrap:
  assert property (@(posedge clk_i) disable iff (rst_i)
    enable && dec.step && dec.fwd && pos_ff == position_limit && !wr_go
    && !(idx_rise && !position_reset_select) |=> pos_ff == 32'h0)
    else $error("forward step past limit did not wrap to zero");

  a_pos_rev_wrap:
  assert property (@(posedge clk_i) disable iff (rst_i)
    enable && dec.step && !dec.fwd && pos_ff == 32'h0 && !wr_go
    && !(idx_rise && !position_reset_select) |=> pos_ff == $past(position_limit))
    else $error("backward step from zero did not wrap to limit");

  a_index_clear:
  assert property (@(posedge clk_i) disable iff (rst_i)
    enable && !position_reset_select && idx_rise && !wr_go |=> pos_ff == 32'h0)
    else $error("index pulse did not clear position");

  a_error_no_move:
  assert property (@(posedge clk_i) disable iff (rst_i)
    enable && dec.err && !wr_go && !idx_rise |=> $stable(pos_ff) ##0 raw_ff[3])
    else $error("phase error moved position or was not flagged");

  a_timer_reload:
  assert property (@(posedge clk_i) disable iff (rst_i)
    expire |=> time_ff == $past(velocity_period_reload))
    else $error("timer did not reload the cycle after zero");

  a_result_copy:
  assert property (@(posedge clk_i) disable iff (rst_i)
    expire |=> velocity_accumulator == 32'h0
    && velocity_result == $past(velocity_accumulator) + 32'($past(vel_inc)))
    else $error("period end did not move the accumulator");

  a_vel_gated:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !enable ##1 !enable |-> $stable(velocity_accumulator) && !expire)
    else $error("velocity ran without position enabled");

  a_set_wins:
  assert property (@(posedge clk_i) disable iff (rst_i)
    ev != 4'h0 |=> (raw_ff & $past(ev)) == $past(ev))
    else $error("event lost against a clear");

  a_ack_single:
  assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule : quadrature_position_velocity
`default_nettype wire

// *** test/qpv_encoder_model.sv ***
// incremental encoder model driving the phase and index pins
`timescale 1ns/1ps
`default_nettype none
module qpv_encoder_model (
  // clock
  input wire logic clk_i,
  // encoder pins
  output logic phase_a_o,
  output logic phase_b_o,
  output logic index_o
);
  logic [1:0] q; // gray state, counting up means a leads b

  // pins start low
  initial
  begin
    q = 2'h0;
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    index_o = 1'b0;
  end

  // drive just after an edge, hold four cycles so the pipe sees it
  task put(input logic a, input logic b);
    @(posedge clk_i);
    phase_a_o <= a;
    phase_b_o <= b;
    repeat (3) @(posedge clk_i);
  endtask : put

  // one quarter step, phases 90 degrees apart
  task quad(input logic fwd);
    q = fwd ? q + 2'h1 : q - 2'h1;
    put(q[1] ^ q[0], q[1]);
  endtask : quad

  // wiring fault: both phases flip together
  task both();
    q = q + 2'h2;
    put(q[1] ^ q[0], q[1]);
  endtask : both

  // clock/direction: set level on b, then one pulse on a
  task step(input logic fwd);
    put(1'b0, !fwd);
    put(1'b1, !fwd);
    put(1'b0, !fwd);
    q = fwd ? 2'h0 : 2'h3;
  endtask : step

  // both low, only used while the block is disabled
  task park();
    put(1'b0, 1'b0);
    q = 2'h0;
  endtask : park

  // index pulse, three cycles high
  task pulse();
    @(posedge clk_i);
    index_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    index_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
endmodule : qpv_encoder_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the quadrature position and velocity block
`timescale 1ns/1ps
`default_nettype none
`include "qpv_cfg.svh"
module testbench;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk_i;
  logic rst_i;
  qpv_pkg::wb_req_t req; // bus request, moved as one
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic pa, pb, px; // encoder pins
  int bad_count, comparisons, ticks;
  logic [31:0] rng, r, pos, lim, e;
  logic cap, swp, res, dir;
  int t0, t1;

  quadrature_position_velocity quadrature_position_velocity_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
    .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .phase_a_input_i(pa), .phase_b_input_i(pb), .index_input_i(px), .irq_o(irq));
  qpv_encoder_model qpv_encoder_model_inst (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb),
    .index_o(px));

  // 50 mhz clock and a free cycle count for period checks
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) ticks <= ticks + 1;

  // ****************************************
  // helpers
  // ****************************************
  // xorshift, fixed seed so runs repeat
  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // does this quarter step give a counted edge
  function logic counted(input logic [1:0] q, input logic up);
    return cap | ((up ? !q[0] : q[0]) ^ swp);
  endfunction : counted

  // next position, wrapping both ways at the limit
  function logic [31:0] nxt_pos(input logic [31:0] p, input logic up);
    if (up)
      return (p >= lim) ? 32'h0 : p + 32'h1;
    return (p == 32'h0) ? lim : p - 32'h1;
  endfunction : nxt_pos

  task tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_word

  task cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: irq %b want %b", $time, got, exp);
    end
  endtask : cmp_bit

  // one classic cycle; request held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= w;
    req.adr <= a;
    req.sel <= s;
    req.dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1)
    begin
      bad_count++;
      tally_and_finish();
    end
    r = rdat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    req.we <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    bus(1'b1, a, d, s);
  endtask : wr

  task chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, 4'hf);
    cmp_word(r, x);
  endtask : chk

  // bounded wait for the masked summary, notes the cycle it was seen
  task wait_irq(output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1)
    begin
      bad_count++;
      tally_and_finish();
    end
    t = ticks;
  endtask : wait_irq

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    ticks = 0;
    bad_count = 0;
    comparisons = 0;
    rng = 32'h75d03508;
    dir = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, 0x2c and 0x30 unmapped
    for (int i = 0; i <= 12; i++)
      chk(8'(i * 4), 32'h0);
    // access kinds, byte lanes, read-only and unmapped places
    wr(`QPV_OFF_CTL, 32'hffff_fff6);
    chk(`QPV_OFF_CTL, 32'h0000_01f6);
    wr(`QPV_OFF_CTL, 32'h0);
    wr(`QPV_OFF_LIMIT, 32'hffff_ffff, 4'h2);
    chk(`QPV_OFF_LIMIT, 32'h0000_ff00);
    e = rnd();
    wr(`QPV_OFF_LOAD, e);
    chk(`QPV_OFF_LOAD, e);
    wr(`QPV_OFF_LOAD, 32'h0000_0257);
    wr(`QPV_OFF_ACC, 32'h5);
    chk(`QPV_OFF_ACC, 32'h0);
    wr(8'h30, 32'h5);
    chk(8'h30, 32'h0);
    // quadrature: every edge select, swap and reset select, random motion
    for (int c = 0; c < 4; c++)
    begin
      cap = c[0];
      swp = c[1];
      res = c[0] ^ c[1];
      lim = 32'(rnd() % 9) + 32'h3;
      wr(`QPV_OFF_CTL, 32'h0);
      qpv_encoder_model_inst.park();
      wr(`QPV_OFF_LIMIT, lim);
      wr(`QPV_OFF_POS, 32'h0);
      wr(`QPV_OFF_CTL, {27'h0, res, cap, 1'b0, swp, 1'b1});
      pos = 32'h0;
      repeat (30)
      begin
        r = rnd();
        if (r[4:2] == 3'h0)
        begin
          qpv_encoder_model_inst.pulse();
          pos = res ? pos : 32'h0;
        end
        else
        begin
          if (counted(qpv_encoder_model_inst.q, r[0]))
            pos = nxt_pos(pos, r[0] ^ swp);
          qpv_encoder_model_inst.quad(r[0]);
          dir = !(r[0] ^ swp);
        end
        repeat (2) @(posedge clk_i);
        chk(`QPV_OFF_POS, pos);
      end
      chk(`QPV_OFF_STAT, {30'h0, dir, 1'b0});
    end
    // phase fault: no move, error flag, mask and clear
    wr(`QPV_OFF_CLR, 32'hf);
    qpv_encoder_model_inst.both();
    repeat (2) @(posedge clk_i);
    chk(`QPV_OFF_POS, pos);
    chk(`QPV_OFF_RAW, 32'h8);
    chk(`QPV_OFF_STAT, {30'h0, dir, 1'b1});
    wr(`QPV_OFF_MASK, 32'h8);
    repeat (2) @(posedge clk_i);
    cmp_bit(irq, 1'b1);
    chk(`QPV_OFF_CLR, 32'h8);
    wr(`QPV_OFF_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    cmp_bit(irq, 1'b0);
    wr(`QPV_OFF_CLR, 32'h8);
    chk(`QPV_OFF_RAW, 32'h0);
    // reversal raises the direction event
    qpv_encoder_model_inst.quad(1'b1);
    qpv_encoder_model_inst.quad(1'b1);
    wr(`QPV_OFF_CLR, 32'hf);
    qpv_encoder_model_inst.quad(1'b0);
    repeat (2) @(posedge clk_i);
    cmp_bit(irq, 1'b1);
    wr(`QPV_OFF_CLR, 32'hf);
    qpv_encoder_model_inst.pulse();
    chk(`QPV_OFF_RAW, 32'h1);
    // clock/direction signalling
    wr(`QPV_OFF_CTL, 32'h0);
    qpv_encoder_model_inst.park();
    wr(`QPV_OFF_LIMIT, 32'h64);
    wr(`QPV_OFF_POS, 32'h5);
    wr(`QPV_OFF_CTL, 32'h5);
    e = 32'(rnd() % 5) + 32'h3;
    for (int i = 0; i < e; i++)
      qpv_encoder_model_inst.step(1'b1);
    repeat (2) qpv_encoder_model_inst.step(1'b0);
    chk(`QPV_OFF_POS, e + 32'h3);
    chk(`QPV_OFF_STAT, 32'h2);
    // velocity enable alone counts nothing
    wr(`QPV_OFF_CTL, 32'h0);
    qpv_encoder_model_inst.park();
    wr(`QPV_OFF_CTL, 32'h20);
    repeat (4) qpv_encoder_model_inst.quad(1'b1);
    chk(`QPV_OFF_ACC, 32'h0);
    // velocity capture over each prescale step that fits a period
    cap = 1'b0;
    swp = 1'b0;
    wr(`QPV_OFF_MASK, 32'h2);
    for (int d = 0; d < 3; d++)
    begin
      wr(`QPV_OFF_CTL, 32'h1);
      wr(`QPV_OFF_CLR, 32'hf);
      wr(`QPV_OFF_CTL, {23'h0, 3'(d), 6'h21});
      wait_irq(t0);
      wr(`QPV_OFF_CLR, 32'hf);
      e = 32'h0;
      repeat (8 + rnd() % 9)
      begin
        e = e + 32'(counted(qpv_encoder_model_inst.q, 1'b1));
        qpv_encoder_model_inst.quad(1'b1);
      end
      repeat (2) @(posedge clk_i);
      chk(`QPV_OFF_ACC, e >> d);
      wait_irq(t1);
      cmp_word(32'(t1 - t0), 32'd600);
      chk(`QPV_OFF_RESULT, e >> d);
      chk(`QPV_OFF_ACC, 32'h0);
    end
    // idle timer stays primed with the reload value
    wr(`QPV_OFF_CTL, 32'h1);
    chk(`QPV_OFF_TIME, 32'h0000_0257);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
